// file: logic/ofad_pkg.sv
// Constants and types of the octal framer address decoder
package ofad_pkg;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned N_FRAMERS  = 8;
  localparam int unsigned SRC_PER_FR = 4;
  localparam int unsigned CAP_DEPTH  = 32;
  localparam int unsigned CAP_IDX_W  = 5;

  // Upper address nibble
  localparam logic [3:0] TOP_BCAST  = 4'h8;
  localparam logic [3:0] TOP_GLOBAL = 4'h9;

  // Global register offsets
  localparam logic [11:0] OFS_GCTL0   = 12'h0900;
  localparam logic [11:0] OFS_GCTL1   = 12'h0901;
  localparam logic [11:0] OFS_VMASK_L = 12'h0902;
  localparam logic [11:0] OFS_VMASK_H = 12'h0903;
  localparam logic [11:0] OFS_LOOPBK  = 12'h0904;
  localparam logic [11:0] OFS_AN_MASK = 12'h0905;
  localparam logic [11:0] OFS_VSTAT_L = 12'h0910;
  localparam logic [11:0] OFS_VSTAT_H = 12'h0911;
  localparam logic [11:0] OFS_IDENT   = 12'h0912;
  localparam logic [11:0] OFS_AN_STAT = 12'h0913;
  localparam logic [11:0] OFS_CAP_LO  = 12'h0920;
  localparam logic [11:0] OFS_CAP_HI  = 12'h093F;

  // Reset values
  localparam logic [15:0] RST_REG16  = 16'h0000;
  localparam logic [15:0] RDATA_NONE = 16'h0000;
  // Identification word, value arbitrary
  localparam logic [15:0] IDENT_WORD = 16'h5A50;

  // Register group codes on address bits 7..4
  localparam logic [3:0] GRP_MCTL    = 4'h0;
  localparam logic [3:0] GRP_MSTAT   = 4'h1;
  localparam logic [3:0] GRP_LSTAT   = 4'h2;
  localparam logic [3:0] GRP_ISTAT   = 4'h3;
  localparam logic [3:0] GRP_IMASK   = 4'h4;
  localparam logic [3:0] GRP_TXCAS_A = 4'h5;
  localparam logic [3:0] GRP_TXCAS_B = 4'h6;
  localparam logic [3:0] GRP_RXCAS_A = 4'h7;
  localparam logic [3:0] GRP_RXCAS_B = 4'h8;
  localparam logic [3:0] GRP_TSCTL_A = 4'h9;
  localparam logic [3:0] GRP_TSCTL_B = 4'hA;
  localparam logic [3:0] GRP_TXNAT   = 4'hB;
  localparam logic [3:0] GRP_RXNAT   = 4'hC;
  localparam logic [3:0] GRP_MCTL_HI = 4'hF;

  typedef enum logic [1:0] {
    RGN_FRAMER,
    RGN_BCAST,
    RGN_GLOBAL,
    RGN_UNUSED
  } ofad_region_t;
endpackage

// file: logic/ofad_group_dec.sv
// Per-framer register group access decoder
`timescale 1ns/1ps
`default_nettype none
module ofad_group_dec (
  input  wire logic [3:0] grp,
  output logic            grp_valid,
  output logic            grp_wr_ok
);
  always_comb begin
    grp_valid = 1'b1;
    grp_wr_ok = 1'b0;
    unique case (grp)
      ofad_pkg::GRP_MCTL,
      ofad_pkg::GRP_MCTL_HI,
      ofad_pkg::GRP_IMASK:   grp_wr_ok = 1'b1;  // see R09
      ofad_pkg::GRP_MSTAT,
      ofad_pkg::GRP_LSTAT,
      ofad_pkg::GRP_ISTAT:   grp_wr_ok = 1'b0;  // see R09
      ofad_pkg::GRP_TXCAS_A,
      ofad_pkg::GRP_TXCAS_B,
      ofad_pkg::GRP_TSCTL_A,
      ofad_pkg::GRP_TSCTL_B: grp_wr_ok = 1'b1;
      ofad_pkg::GRP_RXCAS_A,
      ofad_pkg::GRP_RXCAS_B: grp_wr_ok = 1'b0;
      ofad_pkg::GRP_TXNAT:   grp_wr_ok = 1'b1;  // see R10
      ofad_pkg::GRP_RXNAT:   grp_wr_ok = 1'b0;  // see R11
      default: begin
        grp_valid = 1'b0;                       // see R13
        grp_wr_ok = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: logic/ofad_decoder.sv
// Address decoder and global registers of the octal framer
// Summary of operation
// R01: Address bits 11..8 of 0 to 7 route the access to that framer, bits 7..0 pick its register.
// R02: Upper nibble 8 writes the same register in all eight framers at once.
// R03: Upper nibble 9 reaches one shared set of global registers up to the capture area.
// R04: Two read-write vector mask registers cover framers 0-3 and 4-7.
// R05: Two read-only vector status registers summarise unmasked framer interrupt sources.
// R06: One read-write global loopback register controls loopbacks between framers.
// R07: A global analyser interrupt mask register is kept apart from its status.
// R08: A global analyser status register and a 32-byte captured data area exist.
// R09: Bits 7..4 choose master control or interrupt mask (read-write) or status groups (read-only).
// R10: Locations YB0-YBF are transmit national bit buffers, readable and writable.
// R11: Locations YC0-YCF are receive national bit buffers, readable only.
// R12: Addresses 940 to FFF are unused and nothing responds there; reads there still get cpu_rvalid with zero data.
// R13: Writes to read-only or unused places change nothing; unused reads give any value.
`timescale 1ns/1ps
`default_nettype none
module ofad_decoder (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [11:0]  cpu_addr,
  input  wire logic [15:0]  cpu_wdata,
  input  wire logic         cpu_wr,
  input  wire logic         cpu_rd,
  output logic      [15:0]  cpu_rdata,
  output logic              cpu_rvalid,
  output logic      [7:0]   fr_sel,
  output logic              fr_we,
  output logic              fr_re,
  output logic      [7:0]   fr_reg_addr,
  output logic      [15:0]  fr_wdata,
  input  wire logic [127:0] fr_rdata,
  input  wire logic [31:0]  fr_irq_src,
  output logic      [15:0]  glb_ctl0,
  output logic      [15:0]  glb_ctl1,
  output logic      [15:0]  glb_loopback,
  input  wire logic         cap_valid,
  input  wire logic [7:0]   cap_byte,
  output logic              cap_full,
  output logic              analyser_alert
);
  function automatic ofad_pkg::ofad_region_t region_of(
    input logic [11:0] a
  );
    ofad_pkg::ofad_region_t r;
    r = ofad_pkg::RGN_UNUSED;
    if (a[11] == 1'b0) begin
      r = ofad_pkg::RGN_FRAMER;                            // see R01
    end else if (a[11:8] == ofad_pkg::TOP_BCAST) begin
      r = ofad_pkg::RGN_BCAST;                             // see R02
    end else if (a[11:8] == ofad_pkg::TOP_GLOBAL &&
                 a <= ofad_pkg::OFS_CAP_HI) begin
      r = ofad_pkg::RGN_GLOBAL;                            // see R03
    end
    return r;                                              // see R12
  endfunction

  logic                   grp_valid;
  logic                   grp_wr_ok;
  ofad_pkg::ofad_region_t rgn;
  logic                   do_wr;
  logic                   do_rd;

  logic [15:0] ctl0_r,    ctl0_nxt;
  logic [15:0] ctl1_r,    ctl1_nxt;
  logic [15:0] vmask_l_r, vmask_l_nxt;
  logic [15:0] vmask_h_r, vmask_h_nxt;
  logic [15:0] loop_r,    loop_nxt;
  logic [15:0] anmask_r,  anmask_nxt;
  logic [15:0] vstat_l;
  logic [15:0] vstat_h;

  logic [7:0]  sel_r,   sel_nxt;
  logic        we_r,    we_nxt;
  logic        re_r,    re_nxt;
  logic [7:0]  addr_r,  addr_nxt;
  logic [15:0] wdat_r,  wdat_nxt;
  logic [2:0]  fnum_r,  fnum_nxt;
  logic        gread_r, gread_nxt;
  logic        uread_r, uread_nxt;
  logic [15:0] gdat_r,  gdat_nxt;
  logic [15:0] rdat_r,  rdat_nxt;
  logic        rval_r,  rval_nxt;

  logic [7:0]  cap_mem [ofad_pkg::CAP_DEPTH];
  logic [4:0]  cidx_r,  cidx_nxt;
  logic        full_r,  full_nxt;
  logic        cap_we;

  ofad_group_dec u_grp (
    .grp       (cpu_addr[7:4]),
    .grp_valid (grp_valid),
    .grp_wr_ok (grp_wr_ok)
  );

  assign do_wr = cpu_wr;
  assign do_rd = cpu_rd & ~cpu_wr;

  // Unmasked framer interrupt summary
  assign vstat_l = fr_irq_src[15:0]  & ~vmask_l_r;         // see R05
  assign vstat_h = fr_irq_src[31:16] & ~vmask_h_r;         // see R05

  // Global register writes and read data
  always_comb begin
    rgn         = region_of(cpu_addr);
    ctl0_nxt    = ctl0_r;
    ctl1_nxt    = ctl1_r;
    vmask_l_nxt = vmask_l_r;
    vmask_h_nxt = vmask_h_r;
    loop_nxt    = loop_r;
    anmask_nxt  = anmask_r;
    gdat_nxt    = ofad_pkg::RDATA_NONE;
    if (do_wr && rgn == ofad_pkg::RGN_GLOBAL) begin
      unique case (cpu_addr)
        ofad_pkg::OFS_GCTL0:   ctl0_nxt    = cpu_wdata;
        ofad_pkg::OFS_GCTL1:   ctl1_nxt    = cpu_wdata;
        ofad_pkg::OFS_VMASK_L: vmask_l_nxt = cpu_wdata;    // see R04
        ofad_pkg::OFS_VMASK_H: vmask_h_nxt = cpu_wdata;    // see R04
        ofad_pkg::OFS_LOOPBK:  loop_nxt    = cpu_wdata;    // see R06
        ofad_pkg::OFS_AN_MASK: anmask_nxt  = cpu_wdata;    // see R07
        default:               ctl0_nxt    = ctl0_r;       // see R13
      endcase
    end
    if (cpu_addr >= ofad_pkg::OFS_CAP_LO) begin
      gdat_nxt = {8'h00, cap_mem[cpu_addr[4:0]]};          // see R08
    end else begin
      unique case (cpu_addr)
        ofad_pkg::OFS_GCTL0:   gdat_nxt = ctl0_r;
        ofad_pkg::OFS_GCTL1:   gdat_nxt = ctl1_r;
        ofad_pkg::OFS_VMASK_L: gdat_nxt = vmask_l_r;       // see R04
        ofad_pkg::OFS_VMASK_H: gdat_nxt = vmask_h_r;       // see R04
        ofad_pkg::OFS_LOOPBK:  gdat_nxt = loop_r;          // see R06
        ofad_pkg::OFS_AN_MASK: gdat_nxt = anmask_r;        // see R07
        ofad_pkg::OFS_VSTAT_L: gdat_nxt = vstat_l;         // see R05
        ofad_pkg::OFS_VSTAT_H: gdat_nxt = vstat_h;         // see R05
        ofad_pkg::OFS_IDENT:   gdat_nxt = ofad_pkg::IDENT_WORD;
        ofad_pkg::OFS_AN_STAT: gdat_nxt = {15'h0000, full_r}; // see R08
        default:               gdat_nxt = ofad_pkg::RDATA_NONE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl0_r    <= ofad_pkg::RST_REG16;
      ctl1_r    <= ofad_pkg::RST_REG16;
      vmask_l_r <= ofad_pkg::RST_REG16;
      vmask_h_r <= ofad_pkg::RST_REG16;
      loop_r    <= ofad_pkg::RST_REG16;
      anmask_r  <= ofad_pkg::RST_REG16;
    end else if (ce) begin
      ctl0_r    <= ctl0_nxt;
      ctl1_r    <= ctl1_nxt;
      vmask_l_r <= vmask_l_nxt;
      vmask_h_r <= vmask_h_nxt;
      loop_r    <= loop_nxt;
      anmask_r  <= anmask_nxt;
    end
  end

  // Framer access stage and read return stage
  always_comb begin
    sel_nxt   = 8'h00;
    we_nxt    = 1'b0;
    re_nxt    = 1'b0;
    addr_nxt  = cpu_addr[7:0];
    wdat_nxt  = cpu_wdata;
    fnum_nxt  = cpu_addr[10:8];
    gread_nxt = do_rd && rgn == ofad_pkg::RGN_GLOBAL;      // see R03
    uread_nxt = do_rd && rgn != ofad_pkg::RGN_GLOBAL &&
                !(rgn == ofad_pkg::RGN_FRAMER && grp_valid);
    unique case (rgn)
      ofad_pkg::RGN_FRAMER: begin
        if (grp_valid && (do_rd || (do_wr && grp_wr_ok))) begin
          sel_nxt = 8'h01 << cpu_addr[10:8];               // see R01
          we_nxt  = do_wr;                                 // see R13
          re_nxt  = do_rd;
        end
      end
      ofad_pkg::RGN_BCAST: begin
        if (do_wr && grp_valid && grp_wr_ok) begin
          sel_nxt = 8'hFF;                                 // see R02
          we_nxt  = 1'b1;
        end
      end
      ofad_pkg::RGN_GLOBAL: sel_nxt = 8'h00;               // see R03
      ofad_pkg::RGN_UNUSED: sel_nxt = 8'h00;               // see R12
    endcase
    rval_nxt = gread_r | re_r | uread_r;
    if (gread_r) begin
      rdat_nxt = gdat_r;
    end else if (re_r) begin
      rdat_nxt = fr_rdata[{fnum_r, 4'h0} +: 16];
    end else begin
      rdat_nxt = ofad_pkg::RDATA_NONE;                     // see R13
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_r   <= 8'h00;
      we_r    <= 1'b0;
      re_r    <= 1'b0;
      addr_r  <= 8'h00;
      wdat_r  <= ofad_pkg::RST_REG16;
      fnum_r  <= 3'h0;
      gread_r <= 1'b0;
      uread_r <= 1'b0;
      gdat_r  <= ofad_pkg::RDATA_NONE;
      rdat_r  <= ofad_pkg::RDATA_NONE;
      rval_r  <= 1'b0;
    end else if (ce) begin
      sel_r   <= sel_nxt;
      we_r    <= we_nxt;
      re_r    <= re_nxt;
      addr_r  <= addr_nxt;
      wdat_r  <= wdat_nxt;
      fnum_r  <= fnum_nxt;
      gread_r <= gread_nxt;
      uread_r <= uread_nxt;
      gdat_r  <= gdat_nxt;
      rdat_r  <= rdat_nxt;
      rval_r  <= rval_nxt;
    end
  end

  // Analyser capture buffer, cleared by reading its status while full
  always_comb begin
    cidx_nxt = cidx_r;
    full_nxt = full_r;
    cap_we   = cap_valid & ~full_r;
    if (do_rd && cpu_addr == ofad_pkg::OFS_AN_STAT && full_r) begin
      full_nxt = 1'b0;
      cidx_nxt = 5'h00;
    end
    if (cap_we) begin
      cidx_nxt = cidx_r + 5'h01;
      if (cidx_r == 5'h1F) begin
        full_nxt = 1'b1;                                   // see R08
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cidx_r <= 5'h00;
      full_r <= 1'b0;
    end else if (ce) begin
      cidx_r <= cidx_nxt;
      full_r <= full_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce && cap_we && !rst) begin
      cap_mem[cidx_r] <= cap_byte;                         // see R08
    end
  end

  assign fr_sel         = sel_r;
  assign fr_we          = we_r;
  assign fr_re          = re_r;
  assign fr_reg_addr    = addr_r;
  assign fr_wdata       = wdat_r;
  assign cpu_rdata      = rdat_r;
  assign cpu_rvalid     = rval_r;
  assign glb_ctl0       = ctl0_r;
  assign glb_ctl1       = ctl1_r;
  assign glb_loopback   = loop_r;
  assign cap_full       = full_r;
  assign analyser_alert = full_r & ~anmask_r[0];           // see R07
endmodule
`default_nettype wire

// file: verif/ofad_decoder_asserts.sv
// Port checker for the address decoder
`timescale 1ns/1ps
`default_nettype none
module ofad_decoder_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [11:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic        cpu_rvalid,
  input wire logic [7:0]  fr_sel,
  input wire logic        fr_we,
  input wire logic        fr_re,
  input wire logic [15:0] glb_loopback,
  input wire logic        cap_full,
  input wire logic        analyser_alert
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       w;
  logic [3:0] t;
  logic [3:0] g;
  assign w = ce && cpu_wr;
  assign t = cpu_addr[11:8];
  assign g = cpu_addr[7:4];
  AST_FR_SEL: assert property (
    w && t < 4'h8 && g == 4'h0 |=> fr_we && fr_sel == 8'h01 << $past(t))
    else $error("framer select wrong");
  AST_BCAST: assert property (
    w && t == 4'h8 && g == 4'h4 |=> fr_we && fr_sel == 8'hFF)
    else $error("broadcast write wrong");
  AST_HIGH_QUIET: assert property (
    ce && (cpu_wr || cpu_rd) && t > 4'h8 |=> !fr_we && !fr_re)
    else $error("framer strobe on global or unused");
  AST_RO_NO_WE: assert property (
    w && t < 4'h9 && g inside {4'h1, 4'h2, 4'h3} |=> !fr_we)
    else $error("write to status group");
  AST_TXNAT_WE: assert property (
    w && t < 4'h8 && g == 4'hB |=> fr_we)
    else $error("tx buffer write lost");
  AST_RXNAT_NO_WE: assert property (
    w && t < 4'h9 && g == 4'hC |=> !fr_we)
    else $error("rx buffer written");
  AST_RVALID: assert property (
    ce && cpu_rd && !cpu_wr |=> ##1 cpu_rvalid)
    else $error("read answer late");
  AST_LOOPBK: assert property (
    w && cpu_addr == 12'h904 |=> glb_loopback == $past(cpu_wdata))
    else $error("loopback not written");
  AST_ALERT: assert property (
    analyser_alert |-> cap_full)
    else $error("alert without full");
endmodule
bind ofad_decoder ofad_decoder_chk u_chk (.core_clk(core_clk), .rst(rst),
  .ce(ce), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
  .cpu_rd(cpu_rd), .cpu_rvalid(cpu_rvalid), .fr_sel(fr_sel),
  .fr_we(fr_we), .fr_re(fr_re), .glb_loopback(glb_loopback),
  .cap_full(cap_full), .analyser_alert(analyser_alert));
`default_nettype wire

// file: verif/ofad_framer_model.sv
// Behavioural register files of the eight framers
`timescale 1ns/1ps
`default_nettype none
module ofad_framer_model (
  input  wire logic         core_clk,
  input  wire logic [7:0]   fr_sel,
  input  wire logic         fr_we,
  input  wire logic         fr_re,
  input  wire logic [7:0]   fr_reg_addr,
  input  wire logic [15:0]  fr_wdata,
  output logic      [127:0] fr_rdata
);
  logic [15:0] mem [8][256];
  logic        junk = 1'b0;
  always @(posedge core_clk) begin
    junk <= ~junk;
    for (int n = 0; n < 8; n++)
      if (fr_we && fr_sel[n]) mem[n][fr_reg_addr] <= fr_wdata;
  end
  // Idle lanes toggle so stale data never passes
  always_comb
    for (int n = 0; n < 8; n++)
      fr_rdata[16*n +: 16] = (fr_re && fr_sel[n]) ?
        mem[n][fr_reg_addr] : {8{junk, ~junk}};
endmodule
`default_nettype wire

// file: verif/test_octal_framer_address_decoder.sv
// Self-checking bench of the address decoder
`timescale 1ns/1ps
`default_nettype none
module test_octal_framer_address_decoder;
  logic         core_clk, rst, ce, cpu_wr, cpu_rd, cpu_rvalid;
  logic         fr_we, fr_re, cap_valid, cap_full, analyser_alert;
  logic [11:0]  cpu_addr;
  logic [15:0]  cpu_wdata, cpu_rdata, fr_wdata, glb_loopback;
  logic [7:0]   fr_sel, fr_reg_addr, cap_byte, s_sel, s_ra;
  logic [127:0] fr_rdata;
  logic [31:0]  fr_irq_src;
  logic [15:0]  s_wd, s_rd, g_c0, g_c1;
  logic         s_we, s_re, s_rv;
  int           mismatches, compares;
  ofad_decoder dut (.core_clk(core_clk), .rst(rst), .ce(ce),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .fr_sel(fr_sel), .fr_we(fr_we), .fr_re(fr_re),
    .fr_reg_addr(fr_reg_addr), .fr_wdata(fr_wdata), .fr_rdata(fr_rdata),
    .fr_irq_src(fr_irq_src), .glb_ctl0(g_c0), .glb_ctl1(g_c1),
    .glb_loopback(glb_loopback), .cap_valid(cap_valid),
    .cap_byte(cap_byte), .cap_full(cap_full),
    .analyser_alert(analyser_alert));
  ofad_framer_model u_fr (.core_clk(core_clk), .fr_sel(fr_sel),
    .fr_we(fr_we), .fr_re(fr_re), .fr_reg_addr(fr_reg_addr),
    .fr_wdata(fr_wdata), .fr_rdata(fr_rdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One access from a falling edge; strobes at c1, answer at c2
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [15:0] d);
    {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {w, !w, a, d};
    @(negedge core_clk);
    {cpu_wr, cpu_rd} = 2'b00;
    {s_sel, s_we, s_re, s_ra, s_wd} =
      {fr_sel, fr_we, fr_re, fr_reg_addr, fr_wdata};
    @(negedge core_clk);
    {s_rv, s_rd} = {cpu_rvalid, cpu_rdata};
  endtask
  task automatic t_framers;
    for (int n = 0; n < 8; n++) begin
      acc(1'b1, {n[3:0], 8'h05}, 16'h1100 + 16'(n));
      chk(s_sel, 16'(8'h01 << n));
      chk({s_we, s_ra, s_wd}, {1'b1, 8'h05, 16'h1100 + 16'(n)});
      acc(1'b0, {n[3:0], 8'h05}, 16'h0000);
      chk({s_re, s_rv}, 2'b11);
      chk(s_rd, 16'h1100 + 16'(n));
    end
    $display("t_framers done");
  endtask
  task automatic t_bcast;
    acc(1'b1, 12'h842, 16'hA5C3);
    chk({s_we, s_sel}, {1'b1, 8'hFF});
    for (int n = 0; n < 8; n++) begin
      acc(1'b0, {n[3:0], 8'h42}, 16'h0000);
      chk(s_rd, 16'hA5C3);
    end
    acc(1'b0, 12'h842, 16'h0000);
    chk({s_re, s_rd}, 17'h0);
    $display("t_bcast done");
  endtask
  task automatic t_groups;
    logic [15:0] wmap;
    wmap = 16'h8E71;
    for (int g = 0; g < 16; g++) begin
      acc(1'b1, {4'h3, g[3:0], 4'h7}, 16'h0300 + 16'(g));
      chk(s_we, wmap[g]);
    end
    acc(1'b0, 12'h3B7, 16'h0000);
    chk(s_rd, 16'h030B);
    acc(1'b0, 12'h3C7, 16'h0000);
    chk({s_re, s_rv}, 2'b11);
    $display("t_groups done");
  endtask
  task automatic t_globals;
    logic [11:0] ad [6];
    logic [15:0] dv [6];
    ad = '{12'h900, 12'h902, 12'h903, 12'h904, 12'h905, 12'h901};
    dv = '{16'h0F0F, 16'h1234, 16'h8001, 16'hBEEF, 16'h0001, 16'h5555};
    for (int i = 0; i < 6; i++)
      acc(1'b1, ad[i], dv[i]);
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, ad[i], 16'h0000);
      chk(s_rd, dv[i]);
    end
    chk(glb_loopback, 16'hBEEF);
    chk(g_c0, 16'h0F0F);
    chk(g_c1, 16'h5555);
    acc(1'b1, 12'h910, 16'hFFFF);
    acc(1'b0, 12'h910, 16'h0000);
    chk(s_rd, 16'h00CB);
    acc(1'b0, 12'h911, 16'h0000);
    chk(s_rd, 16'h7FFE);
    acc(1'b1, 12'h912, 16'h0000);
    acc(1'b0, 12'h912, 16'h0000);
    chk(s_rd, ofad_pkg::IDENT_WORD);
    acc(1'b1, 12'h940, 16'h1111);
    chk(s_we, 1'b0);
    acc(1'b0, 12'hA55, 16'h0000);
    chk({s_re, s_rv}, 2'b01);
    $display("t_globals done");
  endtask
  task automatic t_capture;
    for (int i = 0; i < 32; i++) begin
      {cap_valid, cap_byte} = {1'b1, 8'h40 + 8'(i)};
      @(negedge core_clk);
    end
    cap_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({cap_full, analyser_alert}, 2'b10);
    acc(1'b1, 12'h905, 16'h0000);
    chk(analyser_alert, 1'b1);
    acc(1'b0, 12'h920, 16'h0000);
    chk(s_rd, 16'h0040);
    acc(1'b0, 12'h93F, 16'h0000);
    chk(s_rd, 16'h005F);
    acc(1'b0, 12'h913, 16'h0000);
    chk({s_rd, cap_full}, 17'h2);
    $display("t_capture done");
  endtask
  task automatic t_reset;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk(glb_loopback, 16'h0000);
    chk(g_c0, 16'h0000);
    chk({cap_full, analyser_alert}, 2'b00);
    acc(1'b0, 12'h904, 16'h0000);
    chk(s_rd, 16'h0000);
    $display("t_reset done");
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
  initial begin
    {rst, ce, cpu_wr, cpu_rd, cap_valid} = 5'b11000;
    {cpu_addr, cpu_wdata, cap_byte} = '0;
    fr_irq_src = 32'hFFFF_00FF;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    t_framers();
    t_bcast();
    t_groups();
    t_globals();
    t_capture();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
